// File: bench/osc_pll_doze_checker.sv
/*
  concurrent checks on the ports of the clock control block.
  assumes clk_en stays high while bus, switch or doze traffic runs.
*/
`timescale 1ns/1ps
module osc_pll_doze_checker
  import clk_ctrl_pkg::*;
(
  // clock and resets
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  input wire logic              other_reset,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // clock path
  input wire logic [2:0]        cur_source,
  input wire logic [3:0]        osc_sel_onehot,
  input wire logic              pll_enable,
  input wire logic              secondary_osc_on,
  input wire logic              io_map_locked,
  input wire logic              cpu_clk_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] exp_oh;
  logic       osc_wr;
  logic [7:0] since_q;
  always_comb begin
    case (cur_source)
      3'h2, 3'h3: exp_oh = 4'h2;
      3'h4:       exp_oh = 4'h4;
      3'h5:       exp_oh = 4'h8;
      default:    exp_oh = 4'h1;
    endcase
  end
  assign osc_wr = avs_write && !avs_waitrequest && (avs_address == OFF_OSC_CTRL);
  // saturates so a long idle spell never wraps back to a small count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_q <= 8'hFF;
    else if (osc_wr) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest && clk_en && !other_reset;
  endsequence
  sequence answer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (req_s |=> answer_s)
    else $error("bus answer not after one wait cycle");
  read_upper_a: assert property (
    !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000)
    else $error("unimplemented read bits not zero");
  src_onehot_a: assert property (
    $stable(cur_source) && $stable(osc_sel_onehot) |-> osc_sel_onehot == exp_oh)
    else $error("oscillator select does not match source");
  pll_mode_on_a: assert property (
    $stable(cur_source) && cur_source inside {3'h1, 3'h3} && !other_reset |-> pll_enable)
    else $error("pll off in a pll source");
  lock_when_off_a: assert property (
    !avs_waitrequest && avs_read && avs_address == OFF_OSC_CTRL && !pll_enable &&
    !$past(pll_enable) && !$past(pll_enable, 2) |-> !avs_readdata[OSC_PLLLOCK_BIT])
    else $error("pll lock reads one while pll disabled");
  doze_gap_a: assert property (!cpu_clk_en && clk_en |-> ##[1:127] cpu_clk_en)
    else $error("cpu clock enable gap too long");
  copy_bits_a: assert property (
    $changed({secondary_osc_on, io_map_locked}) |-> $past(osc_wr, 2))
    else $error("control copy changed without register write");
  switch_time_a: assert property ($changed(cur_source) |-> since_q >= 8'h0A)
    else $error("source changed too soon after request");
endmodule

bind osc_pll_doze_ctrl osc_pll_doze_checker chk_u (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .other_reset(other_reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cur_source(cur_source), .osc_sel_onehot(osc_sel_onehot), .pll_enable(pll_enable),
  .secondary_osc_on(secondary_osc_on), .io_map_locked(io_map_locked),
  .cpu_clk_en(cpu_clk_en)
);

// File: bench/test_osc_pll_doze_ctrl.sv
/*
  self-checking bench: register access, source switching, dividers, locks,
  doze and resets of the clock control block.
  assumes one wait cycle per access and a 20 MHz clock.
*/
`timescale 1ns/1ps
module test_osc_pll_doze_ctrl;
  import clk_ctrl_pkg::*;
  logic        clk, rst_n, clk_en, other_reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, osc_sel_onehot;
  logic [31:0] avs_writedata, avs_readdata;
  logic        failsafe_switch_cfg, pll_locked_in, clock_fail_event, irq_any;
  logic        pll_enable, secondary_osc_on, io_map_locked, cpu_clk_en;
  logic [15:0] pll_in_khz, rd;
  logic [2:0]  cur_source;
  logic [8:0]  frc_divisor;
  logic [25:0] pll_out_khz;
  int          n_fail, check_count, n, m;

  osc_pll_doze_ctrl dut_u (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .other_reset(other_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .failsafe_switch_cfg(failsafe_switch_cfg), .pll_locked_in(pll_locked_in),
    .clock_fail_event(clock_fail_event), .irq_any(irq_any), .pll_in_khz(pll_in_khz),
    .cur_source(cur_source), .osc_sel_onehot(osc_sel_onehot), .pll_enable(pll_enable),
    .frc_divisor(frc_divisor), .pll_out_khz(pll_out_khz),
    .secondary_osc_on(secondary_osc_on), .io_map_locked(io_map_locked),
    .cpu_clk_en(cpu_clk_en)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // request held until waitrequest is sampled low, released right after
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20) n_fail++;
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(nm, 32'(e), 32'(rd));
  endtask

  task automatic osc(input logic [15:0] d);
    bus(1'b1, OFF_UNLOCK, {8'h00, UNLOCK_KEY1});
    bus(1'b1, OFF_UNLOCK, {8'h00, UNLOCK_KEY2});
    bus(1'b1, OFF_OSC_CTRL, d);
  endtask

  task automatic sw(input logic [2:0] s);
    logic [3:0] oh;
    oh = (s == 3'h2 || s == 3'h3) ? 4'h2 : (s == 3'h4) ? 4'h4 : (s == 3'h5) ? 4'h8 : 4'h1;
    osc({5'h00, s, 8'h01});
    n = 0;
    rd = 16'h0001;
    while (rd[0] !== 1'b0 && n < 3000) begin
      bus(1'b0, OFF_OSC_CTRL, 16'h0000);
      n++;
    end
    repeat (2) @(posedge clk);
    chk("source_field", 32'(s), 32'(rd[14:12]));
    chk("cur_source", 32'(s), 32'(cur_source));
    chk("osc_sel_onehot", 32'(oh), 32'(osc_sel_onehot));
    chk("pll_enable", 32'(s == 3'h1 || s == 3'h3), 32'(pll_enable));
  endtask

  task print_verdict;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    n_fail = 0; check_count = 0; rst_n = 1'b0; clk_en = 1'b1; other_reset = 1'b0;
    avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
    avs_byteenable = 4'hF; failsafe_switch_cfg = 1'b0; pll_locked_in = 1'b0;
    clock_fail_event = 1'b0; irq_any = 1'b0; pll_in_khz = 16'h1F40;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("osc_ctrl", OFF_OSC_CTRL, 16'h0000);
    rdchk("clk_div", OFF_CLK_DIV, 16'h3040);
    rdchk("pll_fbd", OFF_PLL_FBD, 16'h0030);
    rdchk("unmapped", 4'h2, 16'h0000);
    chk("pll_out", 32'h0000C350, 32'(pll_out_khz));
    chk("frc_divisor", 32'h1, 32'(frc_divisor));
    chk("cpu_clk_en", 32'h1, 32'(cpu_clk_en));
    bus(1'b1, OFF_OSC_CTRL, 16'h0042);
    rdchk("no_unlock", OFF_OSC_CTRL, 16'h0000);
    osc(16'h0042);
    rdchk("unlocked", OFF_OSC_CTRL, 16'h0042);
    chk("secondary_on", 32'h1, 32'(secondary_osc_on));
    chk("io_locked", 32'h1, 32'(io_map_locked));
    clock_fail_event <= 1'b1;
    @(posedge clk);
    clock_fail_event <= 1'b0;
    rdchk("fail_set", OFF_OSC_CTRL, 16'h004A);
    osc(16'h0040);
    rdchk("fail_clear", OFF_OSC_CTRL, 16'h0040);
    bus(1'b1, OFF_CLK_DIV, 16'h30DF);
    rdchk("pre_post_max", OFF_CLK_DIV, 16'h30DF);
    chk("pll_out_max_pre", 32'h000005EB, 32'(pll_out_khz));
    bus(1'b1, OFF_PLL_FBD, 16'hFFFF);
    rdchk("fbd_width", OFF_PLL_FBD, 16'h01FF);
    chk("pll_out_max_fbd", 32'h00003CB9, 32'(pll_out_khz));
    bus(1'b1, OFF_CLK_DIV, 16'h3080);
    rdchk("post_reserved", OFF_CLK_DIV, 16'h30C0);
    chk("pll_out_min_pre", 32'h0003E9F4, 32'(pll_out_khz));
    bus(1'b1, OFF_CLK_DIV, 16'h3000);
    rdchk("post_two", OFF_CLK_DIV, 16'h3000);
    chk("pll_out_post_two", 32'h000FA7D0, 32'(pll_out_khz));
    bus(1'b1, OFF_CLK_DIV, 16'h3040);
    bus(1'b1, OFF_PLL_FBD, 16'h0030);
    sw(3'h6);
    chk("frc_div16", 32'h10, 32'(frc_divisor));
    sw(3'h7);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, OFF_CLK_DIV, {5'h06, 3'(k), 8'h40});
      repeat (2) @(posedge clk);
      chk("frc_post", (k == 7) ? 32'h100 : 32'h1 << k, 32'(frc_divisor));
    end
    bus(1'b1, OFF_CLK_DIV, 16'h3040);
    sw(3'h4);
    sw(3'h5);
    sw(3'h2);
    sw(3'h1);
    rdchk("lock_by_timer", OFF_OSC_CTRL, 16'h1120);
    sw(3'h0);
    rdchk("lock_off", OFF_OSC_CTRL, 16'h0000);
    pll_locked_in <= 1'b1;
    sw(3'h3);
    rdchk("lock_by_pll", OFF_OSC_CTRL, 16'h3320);
    sw(3'h0);
    bus(1'b1, OFF_CLK_DIV, 16'h0840);
    rdchk("doze_zero", OFF_CLK_DIV, 16'h0040);
    bus(1'b1, OFF_CLK_DIV, 16'h2040);
    bus(1'b1, OFF_CLK_DIV, 16'h2840);
    rdchk("doze_on", OFF_CLK_DIV, 16'h2840);
    m = 0;
    repeat (16) begin
      @(posedge clk);
      m += int'(cpu_clk_en);
    end
    chk("doze_ratio", 32'h4, 32'(m));
    bus(1'b1, OFF_CLK_DIV, 16'h5840);
    rdchk("doze_frozen", OFF_CLK_DIV, 16'h2840);
    irq_any <= 1'b1;
    @(posedge clk);
    irq_any <= 1'b0;
    rdchk("irq_no_recover", OFF_CLK_DIV, 16'h2840);
    bus(1'b1, OFF_CLK_DIV, 16'hA840);
    irq_any <= 1'b1;
    @(posedge clk);
    irq_any <= 1'b0;
    rdchk("irq_recover", OFF_CLK_DIV, 16'hA040);
    m = 0;
    repeat (8) begin
      @(posedge clk);
      m += int'(cpu_clk_en);
    end
    chk("ratio_one", 32'h8, 32'(m));
    bus(1'b1, OFF_CLK_DIV, 16'h3040);
    osc(16'h0080);
    bus(1'b1, OFF_PLL_FBD, 16'h0040);
    rdchk("cfg_off_free", OFF_PLL_FBD, 16'h0040);
    failsafe_switch_cfg <= 1'b1;
    bus(1'b1, OFF_PLL_FBD, 16'h0050);
    rdchk("locked_fbd", OFF_PLL_FBD, 16'h0040);
    bus(1'b1, OFF_CLK_DIV, 16'h3140);
    rdchk("locked_div", OFF_CLK_DIV, 16'h3040);
    osc(16'h0601);
    rdchk("locked_osc", OFF_OSC_CTRL, 16'h0080);
    failsafe_switch_cfg <= 1'b0;
    osc(16'h0002);
    bus(1'b1, OFF_PLL_FBD, 16'h0077);
    other_reset <= 1'b1;
    @(posedge clk);
    other_reset <= 1'b0;
    @(posedge clk);
    rdchk("keep_fbd", OFF_PLL_FBD, 16'h0077);
    rdchk("keep_osc", OFF_OSC_CTRL, 16'h0002);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("por_fbd", OFF_PLL_FBD, 16'h0030);
    rdchk("por_osc", OFF_OSC_CTRL, 16'h0000);
    print_verdict();
  end
endmodule

// File: hw/clk_ctrl_pkg.sv
/*
  constants for the oscillator, pll and doze control block: register offsets,
  field positions, power-on values, source codes, switch states and timing.
  assumes a 20 MHz core clock and a 32-bit avalon-mm register bus.
*/
package clk_ctrl_pkg;

  // bus geometry
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFF_OSC_CTRL    = 4'h0;
  localparam logic [3:0]  OFF_CLK_DIV     = 4'h4;
  localparam logic [3:0]  OFF_PLL_FBD     = 4'h8;
  localparam logic [3:0]  OFF_UNLOCK      = 4'hC;

  // unlock keys, written in this order to the unlock register
  localparam logic [7:0]  UNLOCK_KEY1     = 8'hA5;
  localparam logic [7:0]  UNLOCK_KEY2     = 8'h5A;

  // oscillator_control fields
  localparam int          OSC_CUR_LSB     = 12;
  localparam int          OSC_NEW_LSB     = 8;
  localparam int          OSC_CFGLOCK_BIT = 7;
  localparam int          OSC_IO_MAP_LOCK_BIT  = 6;
  localparam int          OSC_PLLLOCK_BIT = 5;
  localparam int          OSC_FAIL_BIT    = 3;
  localparam int          OSC_SECEN_BIT   = 1;
  localparam int          OSC_SWREQ_BIT   = 0;

  // clock_divisor fields
  localparam int          DIV_ROI_BIT     = 15;
  localparam int          DIV_DOZE_LSB    = 12;
  localparam int          DIV_REDUCTION_ENABLE_BIT   = 11;
  localparam int          DIV_FRC_LSB     = 8;
  localparam int          DIV_POST_LSB    = 6;
  localparam int          DIV_PRE_LSB     = 0;

  // power-on values and the reserved post divider code
  localparam logic [15:0] OSC_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CLK_DIV_RESET   = 16'h3040;
  localparam logic [15:0] PLL_FBD_RESET   = 16'h0030;
  localparam logic [1:0]  POST_RESERVED   = 2'h2;

  // oscillator source codes
  typedef enum logic [2:0] {
    SRC_FRC       = 3'h0,
    SRC_FRC_PLL   = 3'h1,
    SRC_PRI       = 3'h2,
    SRC_PRI_PLL   = 3'h3,
    SRC_SEC       = 3'h4,
    SRC_LOW_POWER_RC_OSC      = 3'h5,
    SRC_FRC_DIV16 = 3'h6,
    SRC_FRC_POST  = 3'h7
  } osc_src_t;

  // clock switch sequencer
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_LOCK = 3'b100
  } sw_state_t;

  // timing
  localparam int          CLK_NS          = 50;
  localparam int          SWITCH_NS       = 500;
  localparam int          SWITCH_CYC      = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PLL_START_NS    = 100000;
  localparam int          PLL_START_CYC   = (PLL_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TMR_W           = 12;

endpackage

// File: hw/osc_pll_doze_ctrl.sv
/*
  oscillator source selection, clock switch sequencing, pll divider settings,
  pll lock and clock fail status, and processor clock reduction (doze).
  assumes an avalon-mm master with waitrequest, a power-on reset on rst_n and
  synchronous inputs from the pll, clock monitor and interrupt controller.
*/
`timescale 1ns/1ps
module osc_pll_doze_ctrl #(
  parameter int FREQ_W = 16
) (
  // clock, power-on reset, clock enable, other reset sources
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          other_reset,
  // avalon-mm slave
  input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // status from the clock system
  input  wire logic                          failsafe_switch_cfg,
  input  wire logic                          pll_locked_in,
  input  wire logic                          clock_fail_event,
  input  wire logic                          irq_any,
  input  wire logic [FREQ_W-1:0]             pll_in_khz,
  // clock path controls
  output logic      [2:0]                    cur_source,
  output logic      [3:0]                    osc_sel_onehot,
  output logic                               pll_enable,
  output logic      [8:0]                    frc_divisor,
  output logic      [FREQ_W+9:0]             pll_out_khz,
  output logic                               secondary_osc_on,
  output logic                               io_map_locked,
  output logic                               cpu_clk_en
);
  import clk_ctrl_pkg::*;

  logic              wait_q;
  logic [31:0]       rdata_q;
  logic [15:0]       rd_mux;
  logic              wr_acc;
  logic [15:0]       wmerged;
  logic              key1_q;
  logic              armed_q;
  logic              osc_wr;
  logic              div_wr;
  logic              fbd_wr;
  logic              cfg_locked;
  logic [2:0]        cur_src_q;
  logic [2:0]        new_src_q;
  logic              cfg_lock_q;
  logic              io_lock_q;
  logic              pll_lock_q;
  logic              fail_q;
  logic              sec_en_q;
  logic              sw_req_q;
  logic              roi_q;
  logic [2:0]        doze_q;
  logic              reduction_enable_q;
  logic [2:0]        fast_rc_postscale_q;
  logic [1:0]        post_q;
  logic [4:0]        pre_q;
  logic [8:0]        fbd_q;
  sw_state_t         sw_state_q;
  logic [2:0]        tgt_q;
  logic [TMR_W-1:0]  sw_cnt_q;
  logic              sw_done;
  logic              pll_on;
  logic [TMR_W-1:0]  pll_tmr_q;
  logic [2:0]        doze_eff;
  logic [6:0]        doze_cnt_q;
  logic [6:0]        doze_mask;
  logic [3:0]        sel_d;
  logic [8:0]        frc_div_d;
  logic [9:0]        mult;
  logic [5:0]        pre_ratio;
  logic [3:0]        post_ratio;

  // pll is used by the two pll-fed source codes only
  function automatic logic src_uses_pll(input logic [2:0] s);
    src_uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction

  // byte lanes above lane 1 (bits above 15) are not implemented
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus handshake: answer one cycle after the request is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (other_reset) begin
        wait_q <= 1'b1;
      end else if ((avs_read || avs_write) && wait_q) begin
        wait_q  <= 1'b0;
        rdata_q <= {16'h0000, rd_mux};
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign wr_acc          = avs_write && !wait_q && !other_reset;

  always_comb begin
    rd_mux = 16'h0000;
    case (avs_address)
      OFF_OSC_CTRL: begin
        rd_mux = {1'b0, cur_src_q, 1'b0, new_src_q, cfg_lock_q, io_lock_q,
                  pll_lock_q, 1'b0, fail_q, 1'b0, sec_en_q, sw_req_q};
      end
      OFF_CLK_DIV: begin
        rd_mux = {roi_q, doze_q, reduction_enable_q, fast_rc_postscale_q, post_q, 1'b0, pre_q};
      end
      OFF_PLL_FBD: begin
        rd_mux = {7'h00, fbd_q};
      end
      OFF_UNLOCK: begin
        rd_mux = {15'h0000, armed_q};
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_comb begin
    wmerged = 16'h0000;
    case (avs_address)
      OFF_OSC_CTRL: begin
        wmerged = lane_merge(rd_mux, avs_writedata, avs_byteenable);
      end
      OFF_CLK_DIV: begin
        wmerged = lane_merge(rd_mux, avs_writedata, avs_byteenable);
      end
      OFF_PLL_FBD: begin
        wmerged = lane_merge(rd_mux, avs_writedata, avs_byteenable);
      end
      default: begin
        wmerged = avs_writedata[15:0];
      end
    endcase
  end

  assign osc_wr = wr_acc && (avs_address == OFF_OSC_CTRL) && armed_q;
  assign div_wr = wr_acc && (avs_address == OFF_CLK_DIV);
  assign fbd_wr = wr_acc && (avs_address == OFF_PLL_FBD);

  assign cfg_locked = cfg_lock_q && failsafe_switch_cfg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key1_q  <= 1'b0;
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (other_reset) begin
        key1_q  <= 1'b0;
        armed_q <= 1'b0;
      end else if (wr_acc) begin
        if (avs_address == OFF_UNLOCK && avs_byteenable[0]) begin
          key1_q  <= (avs_writedata[7:0] == UNLOCK_KEY1);
          armed_q <= key1_q && (avs_writedata[7:0] == UNLOCK_KEY2);
        end else begin
          // any other write, including the guarded one, spends the unlock
          key1_q  <= 1'b0;
          armed_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      new_src_q  <= OSC_CTRL_RESET[OSC_NEW_LSB +: 3];
      cfg_lock_q <= OSC_CTRL_RESET[OSC_CFGLOCK_BIT];
      io_lock_q  <= OSC_CTRL_RESET[OSC_IO_MAP_LOCK_BIT];
      sec_en_q   <= OSC_CTRL_RESET[OSC_SECEN_BIT];
      fail_q     <= OSC_CTRL_RESET[OSC_FAIL_BIT];
      sw_req_q   <= OSC_CTRL_RESET[OSC_SWREQ_BIT];
    end else if (clk_en) begin
      if (osc_wr && !cfg_locked) begin
        new_src_q  <= wmerged[OSC_NEW_LSB +: 3];
        cfg_lock_q <= wmerged[OSC_CFGLOCK_BIT];
      end
      if (osc_wr) begin
        io_lock_q <= wmerged[OSC_IO_MAP_LOCK_BIT];
        sec_en_q  <= wmerged[OSC_SECEN_BIT];
      end
      fail_q <= clock_fail_event || (fail_q && !(osc_wr && !wmerged[OSC_FAIL_BIT]));
      // request set by software, cleared on completion
      sw_req_q <= (osc_wr && !cfg_locked && wmerged[OSC_SWREQ_BIT]) ||
                  (sw_req_q && !sw_done);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      roi_q    <= CLK_DIV_RESET[DIV_ROI_BIT];
      doze_q   <= CLK_DIV_RESET[DIV_DOZE_LSB +: 3];
      reduction_enable_q  <= CLK_DIV_RESET[DIV_REDUCTION_ENABLE_BIT];
      fast_rc_postscale_q <= CLK_DIV_RESET[DIV_FRC_LSB +: 3];
      post_q   <= CLK_DIV_RESET[DIV_POST_LSB +: 2];
      pre_q    <= CLK_DIV_RESET[DIV_PRE_LSB +: 5];
    end else if (clk_en) begin
      if (div_wr) begin
        roi_q <= wmerged[DIV_ROI_BIT];
        if (!reduction_enable_q) begin
          doze_q <= wmerged[DIV_DOZE_LSB +: 3];
        end
        reduction_enable_q <= wmerged[DIV_REDUCTION_ENABLE_BIT] && (doze_eff != 3'h0);
        if (!cfg_locked) begin
          fast_rc_postscale_q <= wmerged[DIV_FRC_LSB +: 3];
          pre_q    <= wmerged[DIV_PRE_LSB +: 5];
          if (wmerged[DIV_POST_LSB +: 2] != POST_RESERVED) begin
            post_q <= wmerged[DIV_POST_LSB +: 2];
          end
        end
      end
      if (roi_q && irq_any) begin
        reduction_enable_q <= 1'b0;
      end
    end
  end

  // the field that will hold after this write, for the enable check
  assign doze_eff = reduction_enable_q ? doze_q : wmerged[DIV_DOZE_LSB +: 3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbd_q <= PLL_FBD_RESET[8:0];
    end else if (clk_en) begin
      if (fbd_wr && !cfg_locked) begin
        fbd_q <= wmerged[8:0];
      end
    end
  end

  assign sw_done = ((sw_state_q == SW_WAIT) && (sw_cnt_q == '0) && !src_uses_pll(tgt_q)) ||
                   ((sw_state_q == SW_LOCK) && pll_lock_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state_q <= SW_IDLE;
      tgt_q      <= 3'h0;
      sw_cnt_q   <= '0;
    end else if (clk_en) begin
      if (other_reset) begin
        sw_state_q <= SW_IDLE;
        sw_cnt_q   <= '0;
      end else begin
        case (sw_state_q)
          SW_IDLE: begin
            if (sw_req_q) begin
              tgt_q      <= new_src_q;
              sw_cnt_q   <= TMR_W'(SWITCH_CYC - 1);
              sw_state_q <= SW_WAIT;
            end
          end
          SW_WAIT: begin
            if (sw_cnt_q != '0) begin
              sw_cnt_q <= sw_cnt_q - 1'b1;
            end else if (src_uses_pll(tgt_q)) begin
              sw_state_q <= SW_LOCK;
            end else begin
              sw_state_q <= SW_IDLE;
            end
          end
          SW_LOCK: begin
            if (pll_lock_q) begin
              sw_state_q <= SW_IDLE;
            end
          end
          default: begin
            sw_state_q <= SW_IDLE;
          end
        endcase
      end
    end
  end

  // current source lives in oscillator_control, so power-on reset only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_src_q <= OSC_CTRL_RESET[OSC_CUR_LSB +: 3];
    end else if (clk_en) begin
      if (sw_done) begin
        cur_src_q <= tgt_q;
      end
    end
  end

  // pll runs for the active source and while switching onto a pll source
  assign pll_on = src_uses_pll(cur_src_q) ||
                  ((sw_state_q != SW_IDLE) && src_uses_pll(tgt_q));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_tmr_q  <= TMR_W'(PLL_START_CYC);
      pll_lock_q <= 1'b0;
    end else if (clk_en) begin
      if (other_reset || !pll_on) begin
        pll_tmr_q  <= TMR_W'(PLL_START_CYC);
        pll_lock_q <= 1'b0;
      end else begin
        if (pll_tmr_q != '0) begin
          pll_tmr_q <= pll_tmr_q - 1'b1;
        end
        pll_lock_q <= pll_locked_in || (pll_tmr_q == '0);
      end
    end
  end

  // divide by two to the field value
  assign doze_mask = 7'((8'h01 << doze_q) - 8'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doze_cnt_q <= 7'h00;
      cpu_clk_en <= 1'b1;
    end else if (clk_en) begin
      if (other_reset || !reduction_enable_q) begin
        doze_cnt_q <= 7'h00;
        cpu_clk_en <= 1'b1;
      end else begin
        doze_cnt_q <= (doze_cnt_q + 7'h01) & doze_mask;
        cpu_clk_en <= ((doze_cnt_q & doze_mask) == 7'h00);
      end
    end
  end

  always_comb begin
    sel_d     = 4'h0;
    frc_div_d = 9'h001;
    case (cur_src_q)
      SRC_FRC: begin
        sel_d = 4'h1;
      end
      SRC_FRC_PLL: begin
        sel_d     = 4'h1;
        frc_div_d = 9'(9'h001 << fast_rc_postscale_q);
      end
      SRC_PRI: begin
        sel_d = 4'h2;
      end
      SRC_PRI_PLL: begin
        sel_d = 4'h2;
      end
      SRC_SEC: begin
        sel_d = 4'h4;
      end
      SRC_LOW_POWER_RC_OSC: begin
        sel_d = 4'h8;
      end
      SRC_FRC_DIV16: begin
        sel_d     = 4'h1;
        frc_div_d = 9'h010;
      end
      SRC_FRC_POST: begin
        sel_d     = 4'h1;
        frc_div_d = 9'(9'h001 << fast_rc_postscale_q);
      end
      default: begin
        sel_d = 4'h1;
      end
    endcase
    if ((cur_src_q == SRC_FRC_PLL || cur_src_q == SRC_FRC_POST) && fast_rc_postscale_q == 3'h7) begin
      frc_div_d = 9'h100;
    end
  end

  assign mult       = {1'b0, fbd_q} + 10'h002;
  assign pre_ratio  = {1'b0, pre_q} + 6'h02;
  assign post_ratio = (post_q == 2'h3) ? 4'h8 : 4'(4'h2 << post_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_source       <= 3'h0;
      osc_sel_onehot   <= 4'h1;
      frc_divisor      <= 9'h001;
      pll_enable       <= 1'b0;
      pll_out_khz      <= '0;
      secondary_osc_on <= 1'b0;
      io_map_locked    <= 1'b0;
    end else if (clk_en) begin
      cur_source       <= cur_src_q;
      osc_sel_onehot   <= sel_d;
      frc_divisor      <= frc_div_d;
      pll_enable       <= pll_on;
      pll_out_khz      <= (FREQ_W+10)'(({10'h000, pll_in_khz} * {{FREQ_W{1'b0}}, mult}) /
                           ({(FREQ_W+10){1'b0}} | (pre_ratio * post_ratio)));
      secondary_osc_on <= sec_en_q;
      io_map_locked    <= io_lock_q;
    end
  end

endmodule
